// *** src/dcdp_top.sv ***
`timescale 1ns/1ps
module dcdp_top
  import dcdp_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              NRST,
  input  wire logic              TX_CONV_CLOCK_A,
  input  wire logic              TX_CONV_CLOCK_B,
  input  wire logic              TX_WRITE_STROBE_A,
  input  wire logic              TX_WRITE_STROBE_B,
  input  wire logic [WORD_W-1:0] TX_WORD_A,
  input  wire logic [WORD_W-1:0] TX_WORD_B,
  input  wire logic              TX_PORT_SELECT,
  output logic      [WORD_W-1:0] TX_CORE_OUT_A,
  output logic      [WORD_W-1:0] TX_CORE_OUT_B,
  output logic                   TX_CORE_UPDATE_A,
  output logic                   TX_CORE_UPDATE_B,
  output logic                   TX_STREAM_READY,
  output logic                   TX_STREAM_DROP,
  input  wire logic              RX_CONV_CLOCK_A,
  input  wire logic              RX_CONV_CLOCK_B,
  input  wire logic [WORD_W-1:0] RX_ANALOG_A,
  input  wire logic [WORD_W-1:0] RX_ANALOG_B,
  input  wire logic              RX_ANALOG_OVER_A,
  input  wire logic              RX_ANALOG_OVER_B,
  input  wire logic              RX_DRIVE_ENABLE_A,
  input  wire logic              RX_DRIVE_ENABLE_B,
  input  wire logic              RX_MUX_SELECT,
  input  wire logic              RX_POWER_DOWN,
  output logic      [WORD_W-1:0] RX_SAMPLE_WORD_A,
  output logic      [WORD_W-1:0] RX_SAMPLE_WORD_B,
  output logic                   RX_SAMPLE_OE_A,
  output logic                   RX_SAMPLE_OE_B,
  output logic                   RX_OVER_RANGE_A,
  output logic                   RX_OVER_RANGE_B,
  output logic                   RX_MUX_TAG_B
);
  function automatic logic rise(input logic now_v, input logic old_v);
    return now_v & ~old_v;
  endfunction

  logic [CTL_W-1:0]             ctl_in;
  logic [CTL_W-1:0]             ctl_s1_reg;
  logic [CTL_W-1:0]             ctl_s2_reg;
  logic [CTL_W-1:0]             ctl_s3_reg;
  logic [W_N-1:0][WORD_W-1:0]   wd_in;
  logic [W_N-1:0][WORD_W-1:0]   wd_s1_reg;
  logic [W_N-1:0][WORD_W-1:0]   wd_s2_reg;

  assign ctl_in = {RX_POWER_DOWN, RX_MUX_SELECT, RX_DRIVE_ENABLE_B, RX_DRIVE_ENABLE_A,
                   RX_ANALOG_OVER_B, RX_ANALOG_OVER_A, RX_CONV_CLOCK_B, RX_CONV_CLOCK_A,
                   TX_PORT_SELECT, TX_WRITE_STROBE_B, TX_WRITE_STROBE_A,
                   TX_CONV_CLOCK_B, TX_CONV_CLOCK_A};
  assign wd_in  = {RX_ANALOG_B, RX_ANALOG_A, TX_WORD_B, TX_WORD_A};

  // Words are only read on a clock edge seen in ctl_s2, so a skewed bus settles first
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctl_s1_reg <= '0;
      ctl_s2_reg <= '0;
      ctl_s3_reg <= '0;
      wd_s1_reg  <= '0;
      wd_s2_reg  <= '0;
    end else begin
      ctl_s1_reg <= ctl_in;
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
      wd_s1_reg  <= wd_in;
      wd_s2_reg  <= wd_s1_reg;
    end
  end

  logic tx_dual;
  logic tx_take_a;
  logic tx_take_b;
  logic rx_pd;
  logic rx_mux;
  logic rx_rise_a;
  logic rx_fall_a;
  logic rx_rise_b;

  assign tx_dual   = ctl_s2_reg[C_TX_DUAL];
  assign tx_take_a = rise(ctl_s2_reg[C_TX_CLK_A], ctl_s3_reg[C_TX_CLK_A]) & ctl_s2_reg[C_TX_STR_A];
  assign tx_take_b = rise(ctl_s2_reg[C_TX_CLK_B], ctl_s3_reg[C_TX_CLK_B]) & ctl_s2_reg[C_TX_STR_B];
  assign rx_pd     = ctl_s2_reg[C_RX_PD];
  assign rx_mux    = ctl_s2_reg[C_RX_MUX];
  assign rx_rise_a = rise(ctl_s2_reg[C_RX_CLK_A], ctl_s3_reg[C_RX_CLK_A]);
  assign rx_fall_a = rise(ctl_s3_reg[C_RX_CLK_A], ctl_s2_reg[C_RX_CLK_A]);
  assign rx_rise_b = rise(ctl_s2_reg[C_RX_CLK_B], ctl_s3_reg[C_RX_CLK_B]);

  // Interleaved stream: channel A strobes feed the FIFO, channel B clock paces the cores
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic              push_req;

  assign push_req = ~tx_dual & tx_take_a;
  assign fifo_pop = ~tx_dual & fifo_out_valid & rise(ctl_s2_reg[C_TX_CLK_B], ctl_s3_reg[C_TX_CLK_B]);

  dcdp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (wd_s2_reg[W_TX_A]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      TX_STREAM_READY <= 1'b0;
      TX_STREAM_DROP  <= 1'b0;
    end else begin
      TX_STREAM_READY <= fifo_in_ready & ~tx_dual;
      TX_STREAM_DROP  <= push_req & ~fifo_in_ready;
    end
  end

  dcdp_phase_t       phase_reg;
  logic [WORD_W-1:0] hold_i_reg;

  // Phase restarts at I whenever dual mode is selected
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      phase_reg  <= DCDP_PH_I;
      hold_i_reg <= WORD_RST;
    end else if (tx_dual) begin
      phase_reg  <= DCDP_PH_I;
    end else if (fifo_pop) begin
      unique case (phase_reg)
        DCDP_PH_I: begin
          hold_i_reg <= fifo_out_data;
          phase_reg  <= DCDP_PH_Q;
        end
        DCDP_PH_Q: begin
          phase_reg  <= DCDP_PH_I;
        end
      endcase
    end
  end

  logic pair_done;
  assign pair_done = fifo_pop & (phase_reg == DCDP_PH_Q);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      TX_CORE_OUT_A    <= WORD_RST;
      TX_CORE_OUT_B    <= WORD_RST;
      TX_CORE_UPDATE_A <= 1'b0;
      TX_CORE_UPDATE_B <= 1'b0;
    end else begin
      TX_CORE_UPDATE_A <= 1'b0;
      TX_CORE_UPDATE_B <= 1'b0;
      if (tx_dual) begin
        if (tx_take_a) begin
          TX_CORE_OUT_A    <= wd_s2_reg[W_TX_A];
          TX_CORE_UPDATE_A <= 1'b1;
        end
        if (tx_take_b) begin
          TX_CORE_OUT_B    <= wd_s2_reg[W_TX_B];
          TX_CORE_UPDATE_B <= 1'b1;
        end
      end else if (pair_done) begin
        TX_CORE_OUT_A    <= hold_i_reg;
        TX_CORE_OUT_B    <= fifo_out_data;
        TX_CORE_UPDATE_A <= 1'b1;
        TX_CORE_UPDATE_B <= 1'b1;
      end
    end
  end

  // Receive sampling; power-down freezes both channels
  logic [WORD_W-1:0] samp_a_reg;
  logic [WORD_W-1:0] samp_b_reg;
  logic [WORD_W-1:0] mux_b_reg;
  logic              ovr_a_reg;
  logic              ovr_b_reg;
  logic              mux_ovr_b_reg;
  logic              tag_b_reg;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      samp_a_reg    <= WORD_RST;
      ovr_a_reg     <= 1'b0;
      mux_b_reg     <= WORD_RST;
      mux_ovr_b_reg <= 1'b0;
      tag_b_reg     <= 1'b0;
    end else if (!rx_pd) begin
      if (rx_rise_a) begin
        samp_a_reg    <= wd_s2_reg[W_RX_A];
        ovr_a_reg     <= ctl_s2_reg[C_RX_OVR_A];
        mux_b_reg     <= wd_s2_reg[W_RX_B];
        mux_ovr_b_reg <= ctl_s2_reg[C_RX_OVR_B];
        tag_b_reg     <= 1'b0;
      end else if (rx_fall_a && rx_mux) begin
        samp_a_reg    <= mux_b_reg;
        ovr_a_reg     <= mux_ovr_b_reg;
        tag_b_reg     <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      samp_b_reg <= WORD_RST;
      ovr_b_reg  <= 1'b0;
    end else if (!rx_pd && rx_rise_b) begin
      samp_b_reg <= wd_s2_reg[W_RX_B];
      ovr_b_reg  <= ctl_s2_reg[C_RX_OVR_B];
    end
  end

  logic en_a;
  logic en_b;
  assign en_a = ctl_s2_reg[C_RX_OE_A] & ~rx_pd;
  assign en_b = ctl_s2_reg[C_RX_OE_B] & ~rx_pd;

  // Disabled buses read as zero, standing in for a released bus
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      RX_SAMPLE_WORD_A <= WORD_RST;
      RX_SAMPLE_WORD_B <= WORD_RST;
      RX_SAMPLE_OE_A   <= 1'b0;
      RX_SAMPLE_OE_B   <= 1'b0;
      RX_OVER_RANGE_A  <= 1'b0;
      RX_OVER_RANGE_B  <= 1'b0;
      RX_MUX_TAG_B     <= 1'b0;
    end else begin
      RX_SAMPLE_OE_A   <= en_a;
      RX_SAMPLE_OE_B   <= en_b;
      RX_SAMPLE_WORD_A <= en_a ? samp_a_reg : WORD_RST;
      RX_SAMPLE_WORD_B <= en_b ? samp_b_reg : WORD_RST;
      RX_OVER_RANGE_A  <= en_a & ovr_a_reg;
      RX_OVER_RANGE_B  <= en_b & ovr_b_reg;
      RX_MUX_TAG_B     <= en_a & rx_mux & tag_b_reg;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_dual_update_a: assert property (tx_dual && tx_take_a |=> TX_CORE_UPDATE_A &&
    TX_CORE_OUT_A == $past(wd_s2_reg[W_TX_A]))
    else $error("dual port A word not latched");
  a_dual_update_b: assert property (tx_dual && tx_take_b |=> TX_CORE_UPDATE_B &&
    TX_CORE_OUT_B == $past(wd_s2_reg[W_TX_B]))
    else $error("dual port B word not latched");
  a_ilv_together: assert property (!$past(tx_dual) && TX_CORE_UPDATE_A |-> TX_CORE_UPDATE_B)
    else $error("interleaved cores updated apart");
  a_ilv_pair: assert property (fifo_pop && phase_reg == DCDP_PH_I && !tx_dual |=>
    hold_i_reg == $past(fifo_out_data) && !TX_CORE_UPDATE_A)
    else $error("I word not held or early update");
  a_ilv_q_update: assert property (pair_done && !tx_dual |=> TX_CORE_UPDATE_B &&
    TX_CORE_OUT_A == $past(hold_i_reg) && TX_CORE_OUT_B == $past(fifo_out_data))
    else $error("Q word pair not updated");
  a_rx_sample_b: assert property (!rx_pd && rx_rise_b |=> samp_b_reg == $past(wd_s2_reg[W_RX_B]) &&
    ovr_b_reg == $past(ctl_s2_reg[C_RX_OVR_B]))
    else $error("channel B sample missed");
  a_mux_second: assert property (!rx_pd && rx_mux && rx_fall_a |=>
    samp_a_reg == $past(mux_b_reg) ##1 (RX_MUX_TAG_B == RX_SAMPLE_OE_A))
    else $error("mux B word not on bus A");
  a_rx_bus_off: assert property (!$past(ctl_s2_reg[C_RX_OE_A]) |->
    !RX_SAMPLE_OE_A && RX_SAMPLE_WORD_A == WORD_RST && !RX_OVER_RANGE_A)
    else $error("bus A driven while disabled");
  a_rx_pd_both: assert property (rx_pd |=> !RX_SAMPLE_OE_A && !RX_SAMPLE_OE_B)
    else $error("power-down left a channel on");
endmodule

// *** src/dcdp_pkg.sv ***
// Notes on behaviour
// - The transmit side holds two 14-bit converter cores and takes words at up to 125 MSPS.
// - In dual-port mode each transmit channel latches its own word on its own clock and strobe.
// - In interleaved mode one word stream is split into alternating I and Q words, each latched for its own channel.
// - In interleaved mode both cores update together, once per two input words.
// - The receive side samples two channels separately and gives 14-bit words at up to 65 MSPS.
// - The two receive channels run as independent ports, each on its own host clock.
// - With the multiplex option set, words of both channels are interleaved onto the channel A bus.
// - Multiplexed words appear at twice the per-channel sample rate, one on each edge of the common clock.
// - Each receive channel drives its own over-range flag alongside its data word.
// - Each receive channel drives its bus only while its own output enable is high.
// - One power-down input stops both receive channels together.
package dcdp_pkg;
  localparam int WORD_W      = 14;
  localparam int TX_MAX_MSPS = 125;
  localparam int RX_MAX_MSPS = 65;
  localparam int FIFO_DEPTH  = 16;
  localparam int SYS_MHZ     = 10;

  // Positions in the synchronised control vector
  localparam int C_TX_CLK_A  = 0;
  localparam int C_TX_CLK_B  = 1;
  localparam int C_TX_STR_A  = 2;
  localparam int C_TX_STR_B  = 3;
  localparam int C_TX_DUAL   = 4;
  localparam int C_RX_CLK_A  = 5;
  localparam int C_RX_CLK_B  = 6;
  localparam int C_RX_OVR_A  = 7;
  localparam int C_RX_OVR_B  = 8;
  localparam int C_RX_OE_A   = 9;
  localparam int C_RX_OE_B   = 10;
  localparam int C_RX_MUX    = 11;
  localparam int C_RX_PD     = 12;
  localparam int CTL_W       = 13;

  // Positions in the synchronised word array
  localparam int W_TX_A = 0;
  localparam int W_TX_B = 1;
  localparam int W_RX_A = 2;
  localparam int W_RX_B = 3;
  localparam int W_N    = 4;

  localparam logic [WORD_W-1:0] WORD_RST = 14'h0000;

  typedef enum logic {
    DCDP_PH_I = 1'b0,
    DCDP_PH_Q = 1'b1
  } dcdp_phase_t;
endpackage

// *** src/dcdp_fifo.sv ***
`timescale 1ns/1ps
module dcdp_fifo
  import dcdp_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage is not reset; only the pointers and the count carry state
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Full must mean the write pointer has caught up with the read pointer
  a_fifo_no_overfill: assert property (@(posedge clk) disable iff (!nrst)
    (count_reg == CNT_W'(DEPTH)) |-> !in_ready && (wr_ptr_reg == rd_ptr_reg))
    else $error("fifo accepts while full");
  a_fifo_count_step: assert property (@(posedge clk) disable iff (!nrst)
    (push && !pop) |=> (count_reg == $past(count_reg) + 1'b1))
    else $error("fifo count did not rise on push");
endmodule

// *** tb/dcdp_host.sv ***
`timescale 1ns/1ps
module dcdp_host
  import dcdp_pkg::*;
(
  input  wire logic              clk,
  output logic      [1:0]        tx_clk,
  output logic      [1:0]        tx_str,
  output logic      [WORD_W-1:0] tx_word_a,
  output logic      [WORD_W-1:0] tx_word_b,
  output logic                   tx_dual,
  output logic      [1:0]        rx_clk,
  output logic      [WORD_W-1:0] rx_in_a,
  output logic      [WORD_W-1:0] rx_in_b,
  output logic      [1:0]        rx_over,
  output logic      [1:0]        rx_oe,
  output logic                   rx_mux,
  output logic                   rx_pd
);
  initial begin
    {tx_clk, tx_str, tx_word_a, tx_word_b, rx_clk, rx_in_a, rx_in_b, rx_over, rx_mux, rx_pd} = '0;
    tx_dual = 1'b1;
    rx_oe = 2'b11;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic ctl(input logic dual, input logic [1:0] oe, input logic mux, input logic pd);
    @(negedge clk);
    tx_dual = dual;
    rx_oe = oe;
    rx_mux = mux;
    rx_pd = pd;
    gap(5);
  endtask

  // Word and strobe settle three periods ahead; once the hold ends the word is scrambled, not left stale
  task automatic send(input int ch, input logic [WORD_W-1:0] w, input logic str);
    @(negedge clk);
    if (ch == 0) tx_word_a = w;
    else tx_word_b = w;
    tx_str[ch] = str;
    gap(3);
    tx_clk[ch] = 1'b1;
    gap(3);
    tx_clk[ch] = 1'b0;
    tx_str[ch] = 1'b0;
    if (ch == 0) tx_word_a = ~w;
    else tx_word_b = ~w;
    gap(3);
  endtask

  task automatic rx_set(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b, input logic [1:0] ovr);
    @(negedge clk);
    rx_in_a = a;
    rx_in_b = b;
    rx_over = ovr;
    gap(3);
  endtask

  // Clocks stand still between edges; in multiplex mode both pins get the same edge
  task automatic rx_edge(input logic [1:0] which, input logic lvl);
    @(negedge clk);
    rx_clk = lvl ? (rx_clk | which) : (rx_clk & ~which);
    gap(5);
  endtask
endmodule

// *** tb/test_dcdp_top.sv ***
`timescale 1ns/1ps
module test_dcdp_top
  import dcdp_pkg::*;
;
  logic              CLK_SYS;
  logic              NRST;
  logic [1:0]        tx_clk, tx_str, rx_clk, rx_over, rx_oe;
  logic [WORD_W-1:0] tx_wa, tx_wb, rx_ia, rx_ib;
  logic [WORD_W-1:0] out_a, out_b, smp_a, smp_b;
  logic              tx_dual, rx_mux, rx_pd;
  logic              upd_a, upd_b, rdy, drop, oe_a, oe_b, ovr_a, ovr_b, tag_b;
  int                failures, checks_done, n_upd_a, n_upd_b, n_drop, n_skew;

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  dcdp_host h (.clk(CLK_SYS), .tx_clk(tx_clk), .tx_str(tx_str), .tx_word_a(tx_wa), .tx_word_b(tx_wb),
    .tx_dual(tx_dual), .rx_clk(rx_clk), .rx_in_a(rx_ia), .rx_in_b(rx_ib), .rx_over(rx_over),
    .rx_oe(rx_oe), .rx_mux(rx_mux), .rx_pd(rx_pd));

  dcdp_top dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .TX_CONV_CLOCK_A(tx_clk[0]), .TX_CONV_CLOCK_B(tx_clk[1]),
    .TX_WRITE_STROBE_A(tx_str[0]), .TX_WRITE_STROBE_B(tx_str[1]), .TX_WORD_A(tx_wa), .TX_WORD_B(tx_wb),
    .TX_PORT_SELECT(tx_dual), .TX_CORE_OUT_A(out_a), .TX_CORE_OUT_B(out_b), .TX_CORE_UPDATE_A(upd_a),
    .TX_CORE_UPDATE_B(upd_b), .TX_STREAM_READY(rdy), .TX_STREAM_DROP(drop), .RX_CONV_CLOCK_A(rx_clk[0]),
    .RX_CONV_CLOCK_B(rx_clk[1]), .RX_ANALOG_A(rx_ia), .RX_ANALOG_B(rx_ib), .RX_ANALOG_OVER_A(rx_over[0]),
    .RX_ANALOG_OVER_B(rx_over[1]), .RX_DRIVE_ENABLE_A(rx_oe[0]), .RX_DRIVE_ENABLE_B(rx_oe[1]),
    .RX_MUX_SELECT(rx_mux), .RX_POWER_DOWN(rx_pd), .RX_SAMPLE_WORD_A(smp_a), .RX_SAMPLE_WORD_B(smp_b),
    .RX_SAMPLE_OE_A(oe_a), .RX_SAMPLE_OE_B(oe_b), .RX_OVER_RANGE_A(ovr_a), .RX_OVER_RANGE_B(ovr_b),
    .RX_MUX_TAG_B(tag_b));

  // Pulses last one cycle, so they are counted at every edge rather than sampled by the tests
  always @(posedge CLK_SYS) begin
    if (upd_a === 1'b1) n_upd_a++;
    if (upd_b === 1'b1) n_upd_b++;
    if (drop === 1'b1) n_drop++;
    if (upd_a !== upd_b && !tx_dual) n_skew++;
  end

  task automatic chk_w(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_b(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_n(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #2_000_000;
    failures++;
    conclude();
  end

  initial begin
    NRST = 1'b0;
    repeat (10) @(negedge CLK_SYS);
    chk_w("core out a in reset", '0, out_a);
    chk_w("bus a in reset", '0, smp_a);
    chk_b("stream ready in reset", 1'b0, rdy);
    repeat (10) @(negedge CLK_SYS);
    NRST = 1'b1;
    done("reset");
    h.send(0, 14'h1234, 1'b1);
    h.send(1, 14'h2abc, 1'b1);
    chk_w("core out a", 14'h1234, out_a);
    chk_w("core out b", 14'h2abc, out_b);
    h.send(0, 14'h3fff, 1'b0);
    chk_w("core out a idle strobe", 14'h1234, out_a);
    chk_n("updates a", 1, n_upd_a);
    chk_n("updates b", 1, n_upd_b);
    done("dual port");
    h.ctl(1'b0, 2'b11, 1'b0, 1'b0);
    chk_b("stream ready", 1'b1, rdy);
    h.send(0, 14'h0111, 1'b1);
    h.send(0, 14'h0222, 1'b1);
    h.send(1, 14'h0000, 1'b1);
    chk_n("updates a after one pop", 1, n_upd_a);
    h.send(1, 14'h0000, 1'b1);
    chk_w("core out i", 14'h0111, out_a);
    chk_w("core out q", 14'h0222, out_b);
    chk_n("updates a after pair", 2, n_upd_a);
    chk_n("updates b after pair", 2, n_upd_b);
    // Seventeen words into sixteen places: the last one must be refused
    for (int i = 0; i < 17; i++) h.send(0, 14'h0100 + 14'(i), 1'b1);
    chk_n("drops", 1, n_drop);
    chk_b("stream ready full", 1'b0, rdy);
    for (int i = 0; i < 16; i++) h.send(1, 14'h0000, 1'b1);
    chk_w("last i", 14'h010e, out_a);
    chk_w("last q", 14'h010f, out_b);
    chk_n("updates a drained", 10, n_upd_a);
    chk_n("skewed updates", 0, n_skew);
    chk_b("stream ready empty", 1'b1, rdy);
    done("interleaved");
    h.rx_set(14'h1111, 14'h2222, 2'b01);
    h.rx_edge(2'b01, 1'b1);
    h.rx_edge(2'b01, 1'b0);
    chk_w("bus a", 14'h1111, smp_a);
    chk_b("over range a", 1'b1, ovr_a);
    chk_b("drive a", 1'b1, oe_a);
    h.rx_edge(2'b10, 1'b1);
    h.rx_edge(2'b10, 1'b0);
    chk_w("bus b", 14'h2222, smp_b);
    chk_b("over range b", 1'b0, ovr_b);
    chk_w("bus a kept", 14'h1111, smp_a);
    h.ctl(1'b0, 2'b10, 1'b0, 1'b0);
    chk_b("drive a off", 1'b0, oe_a);
    chk_w("bus a off", '0, smp_a);
    chk_b("over range a off", 1'b0, ovr_a);
    chk_w("bus b on", 14'h2222, smp_b);
    h.ctl(1'b0, 2'b11, 1'b0, 1'b1);
    chk_b("drive a down", 1'b0, oe_a);
    chk_b("drive b down", 1'b0, oe_b);
    chk_w("bus b down", '0, smp_b);
    done("receive ports");
    h.ctl(1'b0, 2'b11, 1'b1, 1'b0);
    h.rx_set(14'h0aaa, 14'h0bbb, 2'b10);
    h.rx_edge(2'b11, 1'b1);
    chk_w("mux word a", 14'h0aaa, smp_a);
    chk_b("mux tag a", 1'b0, tag_b);
    chk_b("mux over a", 1'b0, ovr_a);
    h.rx_edge(2'b11, 1'b0);
    chk_w("mux word b", 14'h0bbb, smp_a);
    chk_b("mux tag b", 1'b1, tag_b);
    chk_b("mux over b", 1'b1, ovr_a);
    // Channel B keeps its own bus while A carries the mixed stream
    chk_w("bus b in mux", 14'h0bbb, smp_b);
    chk_b("over range b mux", 1'b1, ovr_b);
    chk_b("drive b mux", 1'b1, oe_b);
    done("multiplex");
    conclude();
  end
endmodule
